//--- design/ptc_pkg.sv
// Constants, types and lookups for the protocol timing configuration block
package ptc_pkg;
  // ****************
  // Timing
  // ****************
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ASYNC_INTERVAL_US = 228;
  localparam int ASYNC_CYCLES_DEF = ASYNC_INTERVAL_US * US_CYCLES;
  // ****************
  // Register indexes (byte address is four times)
  // ****************
  localparam logic [7:0] IDX_MODE = 8'h00;
  localparam logic [7:0] IDX_SRC0 = 8'h1a;
  localparam logic [7:0] IDX_SRC1 = 8'h1b;
  localparam logic [7:0] IDX_TIMING = 8'h22;
  localparam logic [7:0] IDX_START_A = 8'h26;
  localparam logic [7:0] IDX_START_B = 8'h27;
  localparam logic [7:0] IDX_STATUS = 8'h30;
  localparam logic [7:0] IDX_CHECK = 8'h31;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ****************
  // Codes
  // ****************
  localparam logic [3:0] CODE_DSI3 = 4'h0;
  localparam logic [3:0] CODE_PSI5 = 4'h1;
  localparam logic [3:0] MULT_ONE = 4'h1;
  typedef enum logic [1:0] {SUB_ASYNC, SUB_SYNC, SUB_DAISY, SUB_DIAG} psi5_sub_t;
  typedef enum logic [1:0] {OSC_HOLD, OSC_UNTRAINED, OSC_TRAIN} osc_action_t;
  // ****************
  // Field layouts
  // ****************
  typedef struct packed {
    logic [2:0] collect_period_sel;
    logic train_protocol_sel;
    logic calib_value_reset;
    logic [1:0] cmd_resp_period_sel;
    logic calib_enable;
  } timing_cfg_t;
  typedef struct packed {
    logic source_enable;
    logic [2:0] format;
    logic [3:0] source_id;
  } source_cfg_t;
  typedef struct packed {
    logic pad;
    logic daisy_cmd_phase;
    psi5_sub_t psi5_sub;
    logic [3:0] protocol_type_code;
  } mode_cfg_t;
  function automatic logic [11:0] collect_period_us(input logic [2:0] sel);
    logic [11:0] us;
    us = 12'h000;
    case (sel)
      3'h0: us = 12'h064;
      3'h1: us = 12'h07d;
      3'h2: us = 12'h0fa;
      3'h3: us = 12'h14d;
      3'h4: us = 12'h1f4;
      3'h5: us = 12'h320;
      3'h6: us = 12'h3e8;
      default: us = 12'h7d0;
    endcase
    return us;
  endfunction
endpackage

//--- design/protocol_timing_config.sv
// Protocol timing configuration registers with source send control
// Functional notes
// RULE1: PSI5 source settings steer source 0 sends
// RULE2: Enabled source sends at its start time
// RULE3: Timing register accessible in DSI3 or diagnostic
// RULE4: Timing register covered by array check
// RULE5: Period code selects 100 to 2000 us
// RULE6: Period used only for enabled training
// RULE7: DSI3 commands answered regardless of timing
// RULE8: Sync pulses answered regardless of timing
// RULE9: No training in async, diag, daisy command
// RULE10: Select 0 trains per protocol code 0/1
// RULE11: Calibration reset matters only when disabled
// RULE12: Response period is 1,2,4,8 periods
// RULE13: Response period inert in PSI5 mode
// RULE14: Hold, untrained reset, or train oscillator
// RULE15: Each enable switches its data source on
// RULE16: Timing fields at fixed bits, reset zero
// RULE17: Blocked writes leave timing register unchanged
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ns
module protocol_timing_config #(
  parameter int ASYNC_CYCLES = ptc_pkg::ASYNC_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Protocol events from the link front end
  input wire logic sync_pulse,
  input wire logic daisy_slot,
  // Sensor word send requests
  output logic send_word_a,
  output logic send_word_b,
  // Oscillator training control
  output logic train_active,
  output logic train_psi5,
  output ptc_pkg::osc_action_t osc_action,
  output logic [11:0] collect_period,
  output logic [3:0] cmd_resp_mult,
  // Register array check
  output logic [7:0] reg_check
);
  import ptc_pkg::*;

  if (ASYNC_CYCLES < 2) begin : g_chk
    $error("ASYNC_CYCLES must be at least 2");
  end

  // ****************
  // Reset release
  // ****************
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ****************
  // Bus slave
  // ****************
  // One wait state per access, so a read after a write always sees it
  logic pend_r, pend_nxt;
  logic wr_r, wr_nxt;
  logic hit_r, hit_nxt;
  logic [7:0] idx_r, idx_nxt;
  logic rdy_r, rdy_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] rd_mux;
  logic accept;
  logic we;

  assign accept = hsel & htrans[1] & hready;
  assign we = pend_r & wr_r & hit_r;

  always_comb begin
    pend_nxt = 1'b0;
    wr_nxt = wr_r;
    hit_nxt = hit_r;
    idx_nxt = idx_r;
    rdy_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if (accept) begin
      pend_nxt = 1'b1;
      wr_nxt = hwrite;
      hit_nxt = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0);
      idx_nxt = haddr[9:2];
      rdy_nxt = 1'b0;
    end else if (pend_r && !wr_r) begin
      rdata_nxt = hit_r ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pend_r <= 1'b0;
      wr_r <= 1'b0;
      hit_r <= 1'b0;
      idx_r <= 8'h00;
      rdy_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      pend_r <= pend_nxt;
      wr_r <= wr_nxt;
      hit_r <= hit_nxt;
      idx_r <= idx_nxt;
      rdy_r <= rdy_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata = rdata_r;
  assign hreadyout = rdy_r;
  assign hresp = 1'b0;

  // ****************
  // Registers
  // ****************
  mode_cfg_t mode_r, mode_nxt;
  source_cfg_t src_r [2];
  source_cfg_t src_nxt [2];
  timing_cfg_t tim_r, tim_nxt;
  logic [7:0] start_r [2];
  logic [7:0] start_nxt [2];
  logic cfg_ok;
  logic psi5;
  logic [7:0] status;
  logic [7:0] chk_r, chk_nxt;
  logic [1:0] armed_r;

  assign psi5 = mode_r.protocol_type_code == CODE_PSI5;
  // Config access only in DSI3 or PSI5 diagnostic mode
  assign cfg_ok = (mode_r.protocol_type_code == CODE_DSI3) |
                  (psi5 & (mode_r.psi5_sub == SUB_DIAG)); // RULE3

  always_comb begin
    mode_nxt = mode_r;
    src_nxt = src_r;
    tim_nxt = tim_r;
    start_nxt = start_r;
    if (we) begin
      unique case (idx_r)
        IDX_MODE: mode_nxt = mode_cfg_t'({1'b0, hwdata[6:0]});
        IDX_SRC0: if (cfg_ok) src_nxt[0] = source_cfg_t'(hwdata[7:0]);
        IDX_SRC1: if (cfg_ok) src_nxt[1] = source_cfg_t'(hwdata[7:0]);
        IDX_TIMING: if (cfg_ok) tim_nxt = timing_cfg_t'(hwdata[7:0]); // RULE16 RULE17
        IDX_START_A: if (cfg_ok) start_nxt[0] = hwdata[7:0];
        IDX_START_B: if (cfg_ok) start_nxt[1] = hwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r <= mode_cfg_t'(REG_RESET);
      src_r[0] <= source_cfg_t'(REG_RESET);
      src_r[1] <= source_cfg_t'(REG_RESET);
      tim_r <= timing_cfg_t'(REG_RESET); // RULE16
      start_r[0] <= REG_RESET;
      start_r[1] <= REG_RESET;
    end else begin
      mode_r <= mode_nxt;
      src_r <= src_nxt;
      tim_r <= tim_nxt;
      start_r <= start_nxt;
    end
  end

  assign status = {2'h0, armed_r, osc_action, train_psi5, train_active};

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (idx_r)
      IDX_MODE: rd_mux = {25'h0000000, mode_r.daisy_cmd_phase, mode_r.psi5_sub, mode_r.protocol_type_code};
      IDX_SRC0: rd_mux = cfg_ok ? {24'h000000, src_r[0]} : 32'h00000000;
      IDX_SRC1: rd_mux = cfg_ok ? {24'h000000, src_r[1]} : 32'h00000000;
      IDX_TIMING: rd_mux = cfg_ok ? {24'h000000, tim_r} : 32'h00000000; // RULE3 RULE13
      IDX_START_A: rd_mux = cfg_ok ? {24'h000000, start_r[0]} : 32'h00000000;
      IDX_START_B: rd_mux = cfg_ok ? {24'h000000, start_r[1]} : 32'h00000000;
      IDX_STATUS: rd_mux = {24'h000000, status};
      IDX_CHECK: rd_mux = {24'h000000, chk_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ****************
  // Array check
  // ****************
  // Rotating xor so swapped registers still change the check
  always_comb begin
    chk_nxt = {mode_r.daisy_cmd_phase, mode_r.psi5_sub, mode_r.protocol_type_code, 1'b0};
    chk_nxt = {chk_nxt[6:0], chk_nxt[7]} ^ src_r[0];
    chk_nxt = {chk_nxt[6:0], chk_nxt[7]} ^ src_r[1];
    chk_nxt = {chk_nxt[6:0], chk_nxt[7]} ^ tim_r; // RULE4
    chk_nxt = {chk_nxt[6:0], chk_nxt[7]} ^ start_r[0];
    chk_nxt = {chk_nxt[6:0], chk_nxt[7]} ^ start_r[1];
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      chk_r <= 8'h00;
    end else begin
      chk_r <= chk_nxt;
    end
  end

  assign reg_check = chk_r;

  // ****************
  // Time bases
  // ****************
  localparam int ACW = $clog2(ASYNC_CYCLES);
  localparam logic [ACW-1:0] ASYNC_LAST = ACW'(ASYNC_CYCLES - 1);
  localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);
  logic [6:0] us_cnt_r, us_cnt_nxt;
  logic [ACW-1:0] as_cnt_r, as_cnt_nxt;
  logic us_tick;
  logic as_tick;

  assign us_tick = us_cnt_r == US_LAST;
  assign as_tick = as_cnt_r == ASYNC_LAST;

  always_comb begin
    us_cnt_nxt = us_tick ? 7'h00 : us_cnt_r + 7'h01;
    as_cnt_nxt = as_tick ? '0 : as_cnt_r + ACW'(1);
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      us_cnt_r <= 7'h00;
      as_cnt_r <= '0;
    end else begin
      us_cnt_r <= us_cnt_nxt;
      as_cnt_r <= as_cnt_nxt;
    end
  end

  // ****************
  // Send control
  // ****************
  logic in_sync;
  logic [1:0] fire;
  logic [1:0] armed_nxt;
  logic [7:0] slot_r [2];
  logic [7:0] slot_nxt [2];
  logic async_fire;
  logic daisy_fire;
  logic send_a_r, send_b_r;

  // Sync pulses never depend on the timing register
  assign in_sync = psi5 & (mode_r.psi5_sub == SUB_SYNC); // RULE8

  for (genvar i = 0; i < 2; i++) begin : g_src
    always_comb begin
      armed_nxt[i] = armed_r[i];
      slot_nxt[i] = slot_r[i];
      fire[i] = 1'b0;
      if (sync_pulse && in_sync && src_r[i].source_enable) begin // RULE2 RULE15
        armed_nxt[i] = 1'b1;
        slot_nxt[i] = 8'h00;
      end else if (armed_r[i] && us_tick) begin
        if (slot_r[i] == start_r[i]) begin // RULE2
          fire[i] = 1'b1;
          armed_nxt[i] = 1'b0;
        end else begin
          slot_nxt[i] = slot_r[i] + 8'h01;
        end
      end
      if (!in_sync || !src_r[i].source_enable) begin
        armed_nxt[i] = 1'b0;
      end
    end

    always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
        armed_r[i] <= 1'b0;
        slot_r[i] <= 8'h00;
      end else begin
        armed_r[i] <= armed_nxt[i];
        slot_r[i] <= slot_nxt[i];
      end
    end
  end

  // Source 0 sends in async mode and in the daisy data phase (not command phase) whatever its enable
  assign async_fire = psi5 & (mode_r.psi5_sub == SUB_ASYNC) & as_tick; // RULE1
  assign daisy_fire = psi5 & (mode_r.psi5_sub == SUB_DAISY) & ~mode_r.daisy_cmd_phase & daisy_slot; // RULE1

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      send_a_r <= 1'b0;
      send_b_r <= 1'b0;
    end else begin
      send_a_r <= async_fire | daisy_fire | fire[0]; // RULE1
      send_b_r <= fire[1]; // RULE2 RULE15
    end
  end

  assign send_word_a = send_a_r;
  assign send_word_b = send_b_r;

  // ****************
  // Oscillator training
  // ****************
  logic blocked;
  logic proto_ok;
  logic act_r, act_nxt;
  logic tp_r, tp_nxt;
  osc_action_t osc_r, osc_nxt;
  logic [11:0] per_r, per_nxt;
  logic [3:0] mult_r, mult_nxt;

  assign blocked = psi5 & ((mode_r.psi5_sub == SUB_ASYNC) | (mode_r.psi5_sub == SUB_DIAG) |
                   ((mode_r.psi5_sub == SUB_DAISY) & mode_r.daisy_cmd_phase)); // RULE9
  assign proto_ok = ~tim_r.train_protocol_sel & (mode_r.protocol_type_code[3:1] == 3'h0); // RULE10

  always_comb begin
    act_nxt = tim_r.calib_enable & proto_ok & ~blocked; // RULE9 RULE10
    tp_nxt = proto_ok & psi5; // RULE10
    if (tim_r.calib_enable) begin
      osc_nxt = act_nxt ? OSC_TRAIN : OSC_HOLD; // RULE14
    end else begin
      osc_nxt = tim_r.calib_value_reset ? OSC_UNTRAINED : OSC_HOLD; // RULE11 RULE14
    end
    per_nxt = tim_r.calib_enable ? collect_period_us(tim_r.collect_period_sel) : 12'h000; // RULE5 RULE6
    // DSI3 command decode is never gated by this register; only the multiple is reported
    mult_nxt = (mode_r.protocol_type_code == CODE_DSI3) ?
               (MULT_ONE << tim_r.cmd_resp_period_sel) : 4'h0; // RULE7 RULE12 RULE13
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      act_r <= 1'b0;
      tp_r <= 1'b0;
      osc_r <= OSC_HOLD;
      per_r <= 12'h000;
      mult_r <= 4'h0;
    end else begin
      act_r <= act_nxt;
      tp_r <= tp_nxt;
      osc_r <= osc_nxt;
      per_r <= per_nxt;
      mult_r <= mult_nxt;
    end
  end

  assign train_active = act_r;
  assign train_psi5 = tp_r;
  assign osc_action = osc_r;
  assign collect_period = per_r;
  assign cmd_resp_mult = mult_r;
endmodule // protocol_timing_config

//--- verification/sat_master_model.sv
// Control unit bus master model: sync pulses and daisy data slots
`timescale 1ns/1ns
module sat_master_model (
  // Clock
  input wire logic clock,
  // Bus events
  output logic sync_pulse,
  output logic daisy_slot
);
  initial begin
    sync_pulse = 1'b0;
    daisy_slot = 1'b0;
  end
  // One-cycle pulse; callers keep pulses far apart
  task automatic pulse(input logic daisy);
    @(posedge clock);
    if (daisy)
      daisy_slot <= 1'b1;
    else
      sync_pulse <= 1'b1;
    @(posedge clock);
    sync_pulse <= 1'b0;
    daisy_slot <= 1'b0;
  endtask
endmodule // sat_master_model

//--- verification/ptc_sva.sv
// Concurrent checks on the protocol timing configuration ports
`timescale 1ns/1ns
module ptc_sva #(
  parameter int ASYNC_CYCLES = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  // Outputs
  input wire logic send_word_b,
  input wire logic train_active,
  input wire logic train_psi5,
  input wire ptc_pkg::osc_action_t osc_action,
  input wire logic [11:0] collect_period,
  input wire logic [3:0] cmd_resp_mult
);
  import ptc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  one_wait_a: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("wait state wrong");
  period_set_a: assert property (collect_period != 12'h000 |-> collect_period inside
    {12'h064, 12'h07d, 12'h0fa, 12'h14d, 12'h1f4, 12'h320, 12'h3e8, 12'h7d0}) else $error("bad period");
  resp_mult_a: assert property (cmd_resp_mult inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8})
    else $error("bad multiple");
  train_osc_a: assert property (train_active |-> osc_action == OSC_TRAIN && collect_period != 12'h000)
    else $error("training state wrong");
  untrained_idle_a: assert property (osc_action == OSC_UNTRAINED |-> !train_active && collect_period == 12'h000)
    else $error("untrained while enabled");
  psi5_resp_a: assert property (train_active && train_psi5 |-> cmd_resp_mult == 4'h0)
    else $error("response period active in psi5");
  dsi3_train_a: assert property (train_active && !train_psi5 |-> cmd_resp_mult != 4'h0)
    else $error("dsi3 training outside dsi3");
  b_pulse_a: assert property (send_word_b |=> !send_word_b)
    else $error("long send pulse");
  cover property (train_active && train_psi5);
  cover property (send_word_b);
  cover property (osc_action == OSC_UNTRAINED);
endmodule // ptc_sva
bind protocol_timing_config ptc_sva #(.ASYNC_CYCLES(ASYNC_CYCLES)) ptc_sva_i (.*);

//--- verification/test_protocol_timing_config.sv
// Self-checking bench for the protocol timing configuration block
`timescale 1ns/1ns
module test_protocol_timing_config;
  import ptc_pkg::*;
  localparam logic [11:0] PER [8] = '{12'h064, 12'h07d, 12'h0fa, 12'h14d, 12'h1f4, 12'h320, 12'h3e8, 12'h7d0};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, sync_pulse, daisy_slot, send_word_a, send_word_b, train_active, train_psi5;
  osc_action_t osc_action;
  logic [11:0] collect_period;
  logic [3:0] cmd_resp_mult;
  logic [7:0] reg_check, v;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_a = 0;
  int n_b = 0;
  always #5 clock = ~clock;
  protocol_timing_config #(.ASYNC_CYCLES(20)) protocol_timing_config_i (.clock(clock), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sync_pulse(sync_pulse), .daisy_slot(daisy_slot),
    .send_word_a(send_word_a), .send_word_b(send_word_b), .train_active(train_active), .train_psi5(train_psi5),
    .osc_action(osc_action), .collect_period(collect_period), .cmd_resp_mult(cmd_resp_mult), .reg_check(reg_check));
  sat_master_model sat_master_model_i (.clock(clock), .sync_pulse(sync_pulse), .daisy_slot(daisy_slot));
  always @(posedge clock) begin
    cycles <= cycles + 1;
    n_a <= n_a + send_word_a;
    n_b <= n_b + send_word_b;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Single word transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, i, 2'h0};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    chk(rd, e);
  endtask
  // Derived outputs land one cycle after the write commits
  task automatic outs(input logic [19:0] e);
    repeat (2) @(posedge clock);
    chk({train_active, train_psi5, osc_action, cmd_resp_mult, collect_period}, e);
  endtask
  task automatic sends(input int c, input int ea, input int eb);
    int a0;
    int b0;
    a0 = n_a;
    b0 = n_b;
    repeat (c) @(posedge clock);
    chk(n_a - a0, ea);
    chk(n_b - b0, eb);
  endtask
  task automatic t_reset();
    rchk(IDX_TIMING, 32'h0);
    rchk(8'h7f, 32'h0);
    outs(20'h01000);
    chk(reg_check, 8'h00);
  endtask
  task automatic t_codes();
    bus(1'b1, IDX_MODE, 32'h00);
    for (int i = 0; i < 8; i++) begin
      v = {i[2:0], 2'h0, i[1:0], 1'b1};
      bus(1'b1, IDX_TIMING, {24'h0, v});
      outs({1'b1, 1'b0, OSC_TRAIN, 4'h1 << i[1:0], PER[i]});
      chk(reg_check, {v[5:0], v[7:6]});
      rchk(IDX_TIMING, {24'h0, v});
      rchk(IDX_CHECK, {24'h0, v[5:0], v[7:6]});
    end
    bus(1'b1, IDX_TIMING, 32'h11);
    outs({2'h0, OSC_HOLD, 4'h1, 12'h064});
  endtask
  task automatic t_calib();
    bus(1'b1, IDX_TIMING, 32'h08);
    outs({2'h0, OSC_UNTRAINED, 4'h1, 12'h000});
    bus(1'b1, IDX_TIMING, 32'h00);
    outs({2'h0, OSC_HOLD, 4'h1, 12'h000});
    bus(1'b1, IDX_TIMING, 32'h09);
    outs({1'b1, 1'b0, OSC_TRAIN, 4'h1, 12'h064});
  endtask
  task automatic t_gate();
    bus(1'b1, IDX_TIMING, 32'h01);
    bus(1'b1, IDX_MODE, 32'h01);
    outs({2'h1, OSC_HOLD, 4'h0, 12'h064});
    bus(1'b1, IDX_TIMING, 32'hff);
    chk(hresp, 32'h0);
    rchk(IDX_TIMING, 32'h0);
    bus(1'b1, IDX_MODE, 32'h61);
    repeat (2) @(posedge clock);
    chk(train_active, 1'b0);
    bus(1'b1, IDX_MODE, 32'h31);
    repeat (2) @(posedge clock);
    chk(train_active, 1'b0);
    rchk(IDX_TIMING, 32'h01);
  endtask
  task automatic t_sync(input logic [7:0] en_a, input logic [7:0] en_b, input int ea, input int eb);
    bus(1'b1, IDX_MODE, 32'h31);
    bus(1'b1, IDX_SRC0, {24'h0, en_a});
    bus(1'b1, IDX_SRC1, {24'h0, en_b});
    bus(1'b1, IDX_START_A, 32'h00);
    bus(1'b1, IDX_START_B, 32'h01);
    bus(1'b1, IDX_TIMING, 32'h07);
    rchk(IDX_TIMING, 32'h07);
    bus(1'b1, IDX_MODE, 32'h11);
    outs({2'h3, OSC_TRAIN, 4'h0, 12'h064});
    rchk(IDX_STATUS, 32'h0b);
    sat_master_model_i.pulse(1'b0);
    sends(400, ea, eb);
  endtask
  task automatic t_async_daisy();
    bus(1'b1, IDX_MODE, 32'h01);
    repeat (30) @(posedge clock);
    sends(100, 5, 0);
    bus(1'b1, IDX_MODE, 32'h21);
    repeat (30) @(posedge clock);
    sat_master_model_i.pulse(1'b1);
    sends(5, 1, 0);
    bus(1'b1, IDX_MODE, 32'h61);
    sat_master_model_i.pulse(1'b1);
    sends(5, 0, 0);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_codes();
    t_calib();
    t_gate();
    t_sync(8'h80, 8'h80, 1, 1);
    t_sync(8'h00, 8'h00, 0, 0);
    t_async_daisy();
    wrap_up();
  end
endmodule // test_protocol_timing_config
